// [chan_sampler.sv]
// Synchronises channel pins and supervises the channel-bus carrier
`timescale 1ns/10ps
module chan_sampler #(
  parameter int RESP_CYC = gw_pkg::RESP_CYC
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [127:0] chan_in,
  input  wire logic         carrier_in,
  input  wire logic         frame_in,
  input  wire logic         short_in,
  img_if.sampler            img
);
  localparam int W = $clog2(RESP_CYC + 1);
  localparam logic [W-1:0] WD_MAX = W'(RESP_CYC);

  logic [130:0] s1_reg;
  logic [130:0] s2_reg;
  logic         frame_d_reg;
  logic [W-1:0] wd_reg;
  logic         wd_exp_reg;

  // Two-stage synchroniser for every pin; only s2 is looked at
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg      <= '0;
      s2_reg      <= '0;
      frame_d_reg <= 1'b0;
    end else if (ce) begin
      s1_reg      <= {short_in, frame_in, carrier_in, chan_in};
      s2_reg      <= s1_reg;
      frame_d_reg <= s2_reg[129];
    end
  end

  wire frame_edge = s2_reg[129] ^ frame_d_reg;

  // Watchdog: a frame must arrive within the response budget
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wd_reg     <= '0;
      wd_exp_reg <= 1'b1;
    end else if (ce) begin
      if (frame_edge) begin
        wd_reg     <= '0;
        wd_exp_reg <= 1'b0;
      end else if (wd_reg == WD_MAX) begin
        wd_exp_reg <= 1'b1;
      end else begin
        wd_reg <= wd_reg + 1'b1;
      end
    end
  end

  assign img.carrier_ok  = s2_reg[128] & ~wd_exp_reg;
  assign img.short_fault = s2_reg[130];

  // Channel k+1 of group g lands in bit 7-k of byte g
  for (genvar g = 0; g < gw_pkg::GROUPS; g++) begin : g_grp
    for (genvar k = 0; k < gw_pkg::CH_PER_GROUP; k++) begin : g_ch
      assign img.raw_image[g*8+7-k] = s2_reg[g*8+k];
      assign img.in_image[g*8+7-k]  = s2_reg[g*8+k] & img.carrier_ok;
    end
  end

  // A1 flags sync fault, A2 flags channel-bus fault
  assign img.sync_fault = s2_reg[0];
  assign img.bus_fault  = s2_reg[1] | ~img.carrier_ok;
endmodule : chan_sampler

// [dp_master_model.sv]
// Fieldbus master stand-in issuing classic Wishbone cycles
`timescale 1ns/10ps
module dp_master_model (
  input  wire logic        mclk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             wb_cyc,
  output logic             wb_stb,
  output logic             wb_we,
  output logic [7:0]       wb_adr,
  output logic [3:0]       wb_sel,
  output logic [31:0]      wb_dat
);
  // Bus idle at time zero
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_dat = 32'h0000_0000;
  end
  // Only this gateway sits on the segment, so each cycle reaches one slave
  // Called just after an edge; holds the request until ack, then idles one cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask : xfer
endmodule : dp_master_model

// [fieldbus_slave_io_safety_map.sv]
// Gateway top: Wishbone slave, slave address, module image and outputs
//
// Behaviour
// - Slave address from two decimal selectors, 02..99.
// - Sixteen-position selector and DIP switches ignored.
// - Modules selectable in any order and combination.
// - Digital input and output modules, 128 channels.
// - Every data module is sixteen bytes long.
// - Input byte n is group n, channel1 bit7.
// - Output byte n drives group n, bit7 channel1.
// - Safety code 00 safe, 10 open, 11 invalid.
// - Unsafe plus sync, bus or short gives 11.
// - Safety byte per group, pairs in bit pairs.
// - Pair A1/A2 never a safety sender.
// - A1 reads 0 healthy, 1 sync faulty.
// - A2 reads 0 bus healthy, 1 faulty.
// - Missing carrier forces every input off.
// - Gateway response contribution at most 136 ms.
// - Release within 2 ms per channel plus 40.
// - Activate within 4 ms per channel plus 80.
`timescale 1ns/10ps
module fieldbus_slave_io_safety_map #(
  parameter int RESP_CYC = gw_pkg::RESP_CYC,
  parameter int ACT_CYC  = gw_pkg::ACT_CYC
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Wishbone classic slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Address selectors, BCD digits
  input  wire logic [3:0]   addr_tens,
  input  wire logic [3:0]   addr_ones,
  // Channel bus side
  input  wire logic [127:0] chan_in,
  input  wire logic         carrier_in,
  input  wire logic         frame_in,
  input  wire logic         short_in,
  output logic      [127:0] chan_out,
  output logic              loop_safe_o,
  output logic              data_ex_o,
  output logic      [6:0]   slave_addr_o
);
  img_if img ();

  // Pin sampling and carrier supervision
  chan_sampler #(
    .RESP_CYC (RESP_CYC)
  ) u_sampler (
    .mclk       (mclk),
    .resetn     (resetn),
    .ce         (ce),
    .chan_in    (chan_in),
    .carrier_in (carrier_in),
    .frame_in   (frame_in),
    .short_in   (short_in),
    .img        (img.sampler)
  );

  // Safety code image and loop-safe timing
  safety_encoder #(
    .ACT_CYC (ACT_CYC)
  ) u_safety (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .img    (img.encoder)
  );

  // Slave address selectors
  logic [7:0] sel_s1_reg;
  logic [7:0] sel_s2_reg;

  // Selector pins are asynchronous; two flops before use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_s1_reg <= '0;
      sel_s2_reg <= '0;
    end else if (ce) begin
      sel_s1_reg <= {addr_tens, addr_ones};
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // Tens times ten is eight plus two, avoids a multiplier
  wire [3:0] tens_d = sel_s2_reg[7:4];
  wire [3:0] ones_d = sel_s2_reg[3:0];
  wire [6:0] tens_x10 = {tens_d[3:0], 3'b000} + {2'b00, tens_d[3:0], 1'b0};
  wire [6:0] addr_calc = tens_x10 + {3'b000, ones_d};
  wire digits_ok = (tens_d <= gw_pkg::DIGIT_MAX) && (ones_d <= gw_pkg::DIGIT_MAX);
  wire addr_ok = digits_ok && (addr_calc >= gw_pkg::ADDR_MIN) &&
                 (addr_calc <= gw_pkg::ADDR_MAX);
  // The extra selector and DIP switches have no pins here at all

  // Wishbone decode
  logic                ack_reg;
  logic [31:0]         dat_reg;
  logic [5:0]          cfg_reg;
  logic [127:0]        out_img_reg;
  logic [6:0]          addr_reg;
  logic                safe_out_reg;
  gw_pkg::dp_state_t   state_reg;
  gw_pkg::dp_state_t   state_next;

  // A new request is taken only while no ack is pending
  wire req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_req    = req & wb_we_i;
  wire rd_req    = req & ~wb_we_i;
  wire hit_stat  = (wb_adr_i == gw_pkg::OFS_STATUS);
  wire hit_cfg   = (wb_adr_i == gw_pkg::OFS_CONFIG);
  wire hit_img   = (wb_adr_i >= gw_pkg::OFS_IMAGE) && (wb_adr_i < gw_pkg::OFS_IMAGE_END);
  wire [7:0] img_off = wb_adr_i - gw_pkg::OFS_IMAGE;
  wire [1:0] slot    = img_off[5:4];
  wire [1:0] wsel    = img_off[3:2];
  wire data_ex       = (state_reg == gw_pkg::DP_DATA_EX);

  // Module code of the addressed slot; slots stack in selected order
  wire [1:0] slot_mod = (slot == 2'd0) ? cfg_reg[1:0] :
                        (slot == 2'd1) ? cfg_reg[3:2] : cfg_reg[5:4];
  wire cfg_wr = wr_req & hit_cfg & wb_sel_i[0];
  // Any code in any slot is accepted, duplicates too
  wire [5:0] cfg_next = cfg_wr ? wb_dat_i[5:0] : cfg_reg;
  wire img_wr = wr_req & hit_img & data_ex & (slot_mod == gw_pkg::MOD_DO);

  // Each module is a sixteen-byte vector, byte n at bits 8n+7..8n
  wire [127:0] mod_vec = (slot_mod == gw_pkg::MOD_DI) ? img.in_image :
                         (slot_mod == gw_pkg::MOD_DO) ? out_img_reg :
                         (slot_mod == gw_pkg::MOD_SI) ? img.safe_image : '0;
  wire [31:0] img_word = data_ex ? mod_vec[wsel*32 +: 32] : 32'h0000_0000;

  // Status word assembled from live state
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[gw_pkg::STAT_ADDR_LSB +: 7] = addr_reg;
    stat_word[gw_pkg::STAT_ADDR_OK]   = addr_ok;
    stat_word[gw_pkg::STAT_CARRIER]   = img.carrier_ok;
    stat_word[gw_pkg::STAT_SYNC_FLT]  = img.sync_fault;
    stat_word[gw_pkg::STAT_BUS_FLT]   = img.bus_fault;
    stat_word[gw_pkg::STAT_LOOP_SAFE] = img.loop_safe;
    stat_word[gw_pkg::STAT_DATA_EX]   = data_ex;
  end

  // Unmapped addresses read zero and still get an ack
  wire [31:0] rd_next = hit_stat ? stat_word :
                        hit_cfg  ? {26'h000_0000, cfg_reg} :
                        hit_img  ? img_word : 32'h0000_0000;

  // Data exchange state
  // Exchange starts only with a valid address and a non-empty layout
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      gw_pkg::DP_WAIT_CFG: begin
        if (cfg_wr && (wb_dat_i[5:0] != gw_pkg::CONFIG_RESET) && addr_ok) begin
          state_next = gw_pkg::DP_DATA_EX;
        end
      end
      gw_pkg::DP_DATA_EX: begin
        if (!addr_ok || (cfg_wr && (wb_dat_i[5:0] == gw_pkg::CONFIG_RESET))) begin
          state_next = gw_pkg::DP_WAIT_CFG;
        end
      end
      default: state_next = gw_pkg::DP_WAIT_CFG;
    endcase
  end

  // Output image: byte lanes map to module bytes 4*wsel+lane
  logic [127:0] out_next;
  always_comb begin
    out_next = out_img_reg;
    if (!data_ex) begin
      // Outside exchange the outputs fall back to off
      out_next = '0;
    end else if (img_wr) begin
      for (int j = 0; j < 4; j++) begin
        if (wb_sel_i[j]) begin
          out_next[wsel*32 + j*8 +: 8] = wb_dat_i[j*8 +: 8];
        end
      end
    end
  end

  // Bus handshake: ack one cycle after the request, dropped the next
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg <= req;
      if (rd_req) begin
        dat_reg <= rd_next;
      end
    end
  end

  // Configuration, state and output image
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg     <= gw_pkg::CONFIG_RESET;
      state_reg   <= gw_pkg::DP_WAIT_CFG;
      out_img_reg <= '0;
    end else if (ce) begin
      cfg_reg     <= cfg_next;
      state_reg   <= state_next;
      out_img_reg <= out_next;
    end
  end

  // Registered copies that drive the status outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_reg     <= 7'h00;
      safe_out_reg <= 1'b0;
    end else if (ce) begin
      addr_reg     <= addr_ok ? addr_calc : 7'h00;
      safe_out_reg <= img.loop_safe;
    end
  end

  // Output pins: byte g bit 7-k drives channel k+1 of group g
  for (genvar g = 0; g < gw_pkg::GROUPS; g++) begin : g_out
    for (genvar k = 0; k < gw_pkg::CH_PER_GROUP; k++) begin : g_bit
      assign chan_out[g*8+k] = out_img_reg[g*8+7-k];
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign loop_safe_o  = safe_out_reg;
  assign data_ex_o    = (state_reg == gw_pkg::DP_DATA_EX);
  assign slave_addr_o = addr_reg;
endmodule : fieldbus_slave_io_safety_map

// [fieldbus_slave_io_safety_map_test.sv]
// Self-checking bench for the fieldbus slave gateway
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module fieldbus_slave_io_safety_map_test;
  localparam int RESP = 50;
  localparam int ACT  = 20;
  logic         mclk, resetn, ce, wb_cyc, wb_stb, wb_we, wb_ack, frame_run;
  logic         carrier_in, frame_in, short_in, loop_safe_o, data_ex_o;
  logic [3:0]   addr_tens, addr_ones, wb_sel;
  logic [7:0]   wb_adr;
  logic [31:0]  wb_dat, wb_rdat, q;
  logic [6:0]   slave_addr_o;
  logic [127:0] chan_in, chan_out;
  int           errors, checked;

  fieldbus_slave_io_safety_map #(.RESP_CYC(RESP), .ACT_CYC(ACT)) uut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .addr_tens(addr_tens), .addr_ones(addr_ones),
    .chan_in(chan_in), .carrier_in(carrier_in), .frame_in(frame_in), .short_in(short_in),
    .chan_out(chan_out), .loop_safe_o(loop_safe_o), .data_ex_o(data_ex_o),
    .slave_addr_o(slave_addr_o));
  dp_master_model u_master (.mclk(mclk), .ack(wb_ack), .rdat(wb_rdat), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat(wb_dat));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Frame edges keep the carrier watchdog fed while running
  always @(posedge mclk) if (frame_run) frame_in <= ~frame_in;

  // Module bytes carry channel 1 in bit 7, so each byte is bit-reversed
  function automatic logic [127:0] rev(input logic [127:0] c);
    for (int i = 0; i < 128; i++) rev[i] = c[(i & ~7) + 7 - (i & 7)];
  endfunction : rev
  // Pair (odd, even) to a code; the A1/A2 slot stays 00
  function automatic logic [127:0] safe_img(input logic [127:0] c, input logic flt, lost);
    safe_img = '0;
    for (int p = 1; p < 64; p++) begin
      safe_img[8*(p/4)+7-2*(p%4)-:2] = lost ? 2'b11 : (c[2*p+:2] == 2'b00) ? 2'b00 :
                                       (flt || c[2*p+1]) ? 2'b11 : 2'b10;
    end
  endfunction : safe_img
  task automatic rd(input logic [7:0] a);
    u_master.xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_master.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic chk_slot(input logic [7:0] base, input logic [127:0] img);
    for (int w = 0; w < 4; w++) begin
      rd(base + 8'(4 * w));
      `CHK(q, img[32*w+:32])
    end
  endtask : chk_slot

  task automatic t_status;
    rd(gw_pkg::OFS_STATUS);
    `CHK(q[10:0], {4'h3, 7'h2A})
    rd(gw_pkg::OFS_CONFIG);
    `CHK(q[5:0], 6'h00)
    rd(8'h80);
    `CHK(q, 32'h0000_0000)
    $display("t_status done");
  endtask : t_status
  task automatic t_addr;
    logic [3:0] tt [7] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'hA, 4'h1, 4'h4};
    logic [3:0] oo [7] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'h0, 4'hA, 4'h2};
    logic [6:0] ee [7] = '{7'h00, 7'h00, 7'h02, 7'h63, 7'h00, 7'h00, 7'h2A};
    for (int i = 0; i < 7; i++) begin
      addr_tens <= tt[i];
      addr_ones <= oo[i];
      repeat (6) @(posedge mclk);
      `CHK(slave_addr_o, ee[i])
    end
    $display("t_addr done");
  endtask : t_addr
  task automatic t_config;
    wr(gw_pkg::OFS_CONFIG, 32'h0000_0039); // DI, DO, SI in slots 0 to 2
    @(posedge mclk);
    `CHK(data_ex_o, 1'b1)
    rd(gw_pkg::OFS_CONFIG);
    `CHK(q[5:0], 6'h39)
    $display("t_config done");
  endtask : t_config
  task automatic t_digital;
    logic [127:0] img;
    chan_in <= 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    repeat (5) @(posedge mclk);
    chk_slot(8'h50 - 8'h10, rev(chan_in));
    for (int w = 0; w < 4; w++) begin
      img[32*w+:32] = {8'(w), 24'hA5_3C_0F};
      wr(8'h50 + 8'(4 * w), img[32*w+:32]);
    end
    wr(8'h40, 32'hFFFF_FFFF); // Input slot must not take writes
    @(posedge mclk);
    `CHK(chan_out, rev(img))
    chk_slot(8'h40, rev(chan_in));
    rd(8'h70);
    `CHK(q, 32'h0000_0000)
    $display("t_digital done");
  endtask : t_digital
  task automatic t_safety;
    chan_in <= {{15{8'h39}}, 8'h38};
    repeat (5) @(posedge mclk);
    chk_slot(8'h60, safe_img(chan_in, 1'b0, 1'b0));
    // Sync fault, bus fault, then short; A1/A2 never act as a sender
    for (int f = 0; f < 3; f++) begin
      chan_in[1:0] <= (f == 0) ? 2'b01 : (f == 1) ? 2'b10 : 2'b00;
      short_in <= (f == 2);
      repeat (5) @(posedge mclk);
      rd(gw_pkg::OFS_STATUS);
      `CHK(q[10:9], {f == 1, f == 0})
      chk_slot(8'h60, safe_img(chan_in, 1'b1, 1'b0));
    end
    short_in <= 1'b0;
    $display("t_safety done");
  endtask : t_safety
  task automatic t_carrier;
    carrier_in <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(gw_pkg::OFS_STATUS);
    `CHK({q[10], q[8]}, 2'b10)
    chk_slot(8'h40, 128'h0);
    chk_slot(8'h60, safe_img(chan_in, 1'b0, 1'b1));
    // Carrier back but frames stopped: only the watchdog can drop it
    carrier_in <= 1'b1;
    frame_run <= 1'b0;
    repeat (RESP - 10) @(posedge mclk);
    rd(gw_pkg::OFS_STATUS);
    `CHK(q[8], 1'b1)
    repeat (20) @(posedge mclk);
    rd(gw_pkg::OFS_STATUS);
    `CHK(q[8], 1'b0)
    frame_run <= 1'b1;
    repeat (8) @(posedge mclk);
    $display("t_carrier done");
  endtask : t_carrier
  task automatic t_loop;
    int n;
    chan_in <= '0;
    repeat (ACT / 2) @(posedge mclk);
    `CHK(loop_safe_o, 1'b0)
    n = ACT / 2;
    while (loop_safe_o !== 1'b1 && n < ACT + 12) begin
      @(posedge mclk);
      n++;
    end
    `CHK(loop_safe_o, 1'b1)
    chan_in[2] <= 1'b1; // Sender A3/A4 opens
    repeat (8) @(posedge mclk);
    `CHK(loop_safe_o, 1'b0)
    $display("t_loop done");
  endtask : t_loop
  task automatic t_leave;
    wr(gw_pkg::OFS_CONFIG, 32'h0000_0000);
    @(posedge mclk);
    `CHK(data_ex_o, 1'b0)
    `CHK(chan_out, 128'h0)
    rd(8'h40);
    `CHK(q, 32'h0000_0000)
    $display("t_leave done");
  endtask : t_leave
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Main sequence; ce stays high so nothing is frozen
  initial begin
    {resetn, frame_in, short_in, errors, checked} = '0;
    {ce, carrier_in, frame_run} = 3'b111;
    addr_tens = 4'h4;
    addr_ones = 4'h2;
    chan_in = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (10) @(posedge mclk);
    t_status;
    t_addr;
    t_config;
    t_digital;
    t_safety;
    t_carrier;
    t_loop;
    t_leave;
    tally_and_finish;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    tally_and_finish;
  end
endmodule : fieldbus_slave_io_safety_map_test

// [gw_asserts.sv]
// Port-level checks for the fieldbus slave gateway
`timescale 1ns/10ps
module gw_asserts #(
  parameter int RESP_CYC = gw_pkg::RESP_CYC,
  parameter int ACT_CYC  = gw_pkg::ACT_CYC
) (
  input wire logic         mclk,
  input wire logic         resetn,
  input wire logic         ce,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [7:0]   wb_adr_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic         wb_ack_o,
  input wire logic [3:0]   addr_tens,
  input wire logic [3:0]   addr_ones,
  input wire logic [127:0] chan_in,
  input wire logic [127:0] chan_out,
  input wire logic         loop_safe_o,
  input wire logic         data_ex_o,
  input wire logic [6:0]   slave_addr_o
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0]  sel_val;
  logic [6:0]  exp_addr;
  logic [31:0] safe_cnt;
  // Selector value; tens or ones above nine, or 00 and 01, give no address
  assign sel_val  = {4'h0, addr_tens} * 8'h0A + {4'h0, addr_ones};
  assign exp_addr = (addr_tens <= 4'h9 && addr_ones <= 4'h9 && sel_val >= 8'h02) ?
                    sel_val[6:0] : 7'h00;
  // Cycles with every sender pair quiet; A1/A2 are not senders
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      safe_cnt <= '0;
    else
      safe_cnt <= (chan_in[127:2] != '0) ? '0 : safe_cnt + 32'h1;
  end
  property p_ack_once; wb_ack_o && ce |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_take; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not answered");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_addr_range;
    slave_addr_o != 7'h00 |-> slave_addr_o >= 7'h02 && slave_addr_o <= 7'h63;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range");
  property p_addr_map;
    ($stable(addr_tens) && $stable(addr_ones))[*6] |-> slave_addr_o == exp_addr;
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("address not from selectors");
  property p_cfg_enter;
    ce && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
    wb_adr_i == gw_pkg::OFS_CONFIG && wb_dat_i[5:0] != 6'h00 && slave_addr_o != 7'h00
    |=> ##[0:1] data_ex_o;
  endproperty
  a_cfg_enter: assert property (p_cfg_enter) else $error("no data exchange");
  property p_out_idle; !data_ex_o && $past(!data_ex_o) |-> chan_out == '0; endproperty
  a_out_idle: assert property (p_out_idle) else $error("outputs live when idle");
  property p_loop_hold; $rose(loop_safe_o) |-> safe_cnt >= ACT_CYC; endproperty
  a_loop_hold: assert property (p_loop_hold) else $error("loop safe too early");
  property p_loop_rel; (chan_in[127:2] != '0)[*8] |-> !loop_safe_o; endproperty
  a_loop_rel: assert property (p_loop_rel) else $error("loop not released");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_loop:  cover property ($rose(loop_safe_o));
  c_leave: cover property ($fell(data_ex_o));
endmodule : gw_asserts

bind fieldbus_slave_io_safety_map gw_asserts #(.RESP_CYC(RESP_CYC), .ACT_CYC(ACT_CYC)) u_chk (
  .mclk(mclk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .addr_tens(addr_tens), .addr_ones(addr_ones), .chan_in(chan_in),
  .chan_out(chan_out), .loop_safe_o(loop_safe_o), .data_ex_o(data_ex_o),
  .slave_addr_o(slave_addr_o));

// [gw_pkg.sv]
// Shared constants and types for the fieldbus slave gateway
package gw_pkg;
  localparam int CLK_HZ       = 40_000_000;
  localparam int GROUPS       = 16;
  localparam int CH_PER_GROUP = 8;
  localparam int CHANNELS     = 128;
  localparam int MODULE_BYTES = 16;
  localparam int SLOTS        = 3;
  // Response budget and relay timing, in ms, then in cycles
  localparam int RESP_MS  = 136;
  localparam int RESP_CYC = RESP_MS * (CLK_HZ / 1000);
  localparam int REL_MS   = 40;
  localparam int ACT_MS   = 80;
  localparam int ACT_CYC  = ACT_MS * (CLK_HZ / 1000);
  // Slave address range
  localparam logic [6:0] ADDR_MIN  = 7'h02;
  localparam logic [6:0] ADDR_MAX  = 7'h63;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_CONFIG    = 8'h04;
  localparam logic [7:0] OFS_IMAGE     = 8'h40;
  localparam logic [7:0] OFS_IMAGE_END = 8'h70;
  // Status field positions
  localparam int STAT_ADDR_LSB  = 0;
  localparam int STAT_ADDR_OK   = 7;
  localparam int STAT_CARRIER   = 8;
  localparam int STAT_SYNC_FLT  = 9;
  localparam int STAT_BUS_FLT   = 10;
  localparam int STAT_LOOP_SAFE = 11;
  localparam int STAT_DATA_EX   = 12;
  localparam logic [5:0] CONFIG_RESET = 6'h00;
  // Module codes per slot
  typedef enum logic [1:0] {
    MOD_NONE = 2'b00, MOD_DI = 2'b01, MOD_DO = 2'b10, MOD_SI = 2'b11
  } mod_t;
  // Safety status codes
  localparam logic [1:0] SAFE_CLOSED    = 2'b00;
  localparam logic [1:0] UNSAFE_OPEN    = 2'b10;
  localparam logic [1:0] UNSAFE_INVALID = 2'b11;
  // Data exchange states
  typedef enum logic {
    DP_WAIT_CFG = 1'b0, DP_DATA_EX = 1'b1
  } dp_state_t;
endpackage : gw_pkg

// [img_if.sv]
// Channel images and health flags passed between gateway modules
`timescale 1ns/10ps
interface img_if;
  logic [127:0] raw_image;
  logic [127:0] in_image;
  logic [127:0] safe_image;
  logic         carrier_ok;
  logic         sync_fault;
  logic         bus_fault;
  logic         short_fault;
  logic         loop_safe;
  modport sampler (output raw_image, in_image, carrier_ok, sync_fault, bus_fault, short_fault);
  modport encoder (input raw_image, carrier_ok, sync_fault, bus_fault, short_fault,
                   output safe_image, loop_safe);
  modport top (input in_image, safe_image, carrier_ok, sync_fault, bus_fault, loop_safe);
endinterface : img_if

// [safety_encoder.sv]
// Builds two-bit safety codes per channel pair and the loop-safe level
`timescale 1ns/10ps
module safety_encoder #(
  parameter int ACT_CYC = gw_pkg::ACT_CYC
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  img_if.encoder    img
);
  localparam int W = $clog2(ACT_CYC + 1);
  localparam logic [W-1:0] ACT_MAX = W'(ACT_CYC);

  logic [W-1:0] act_reg;
  logic         safe_reg;
  wire          link_fault = img.sync_fault | img.bus_fault | img.short_fault;

  // Pair p of group g occupies bits 7-2p and 6-2p of byte g
  for (genvar g = 0; g < gw_pkg::GROUPS; g++) begin : g_grp
    for (genvar p = 0; p < 4; p++) begin : g_pair
      wire [1:0] raw = {img.raw_image[g*8+7-2*p], img.raw_image[g*8+6-2*p]};
      wire [1:0] base = (raw == gw_pkg::SAFE_CLOSED) ? gw_pkg::SAFE_CLOSED :
                        (raw == gw_pkg::UNSAFE_OPEN) ? gw_pkg::UNSAFE_OPEN :
                        gw_pkg::UNSAFE_INVALID;
      wire [1:0] code = (!img.carrier_ok) ? gw_pkg::UNSAFE_INVALID :
                        (base != gw_pkg::SAFE_CLOSED && link_fault) ?
                        gw_pkg::UNSAFE_INVALID : base;
      if (g == 0 && p == 0) begin : g_sync
        // A1/A2 carry sync and supervision, never a safety sender
        assign img.safe_image[7:6] = 2'b00;
      end else begin : g_code
        assign img.safe_image[g*8+7-2*p -: 2] = code;
      end
    end
  end

  wire all_safe = (img.safe_image == '0) & img.carrier_ok & ~link_fault;

  // Release at once on any unsafe code; activate only after a steady safe
  // period, so a chattering sender cannot pull the loop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      act_reg  <= '0;
      safe_reg <= 1'b0;
    end else if (ce) begin
      if (!all_safe) begin
        act_reg  <= '0;
        safe_reg <= 1'b0;
      end else if (act_reg == ACT_MAX) begin
        safe_reg <= 1'b1;
      end else begin
        act_reg <= act_reg + 1'b1;
      end
    end
  end

  assign img.loop_safe = safe_reg;
endmodule : safety_encoder
